// file: hdl/dpais_sched.sv
// Summary of operation
// - Host auto-precharge honoured only on last beat
// - Open-page policy leaves page open otherwise
// - Page is rank, bank group, bank and row
// - Activate then column command tRCD minus AL cycles later, at least one
// - Additive latency kept no larger than tRCD
// - Read data expected after AL plus CL
// - Write data driven after AL plus CL minus one
// - Non-interleaved order: rank, BG, bank, CID, row, col
// - Bank interleave: rank, CID, row, col, bank, BG
// - Rank and bank interleave: CID, row, rank, bank, col, BG
// - Overlap activate of one bank with another's access
// - Four bank groups, two for sixteen-bit devices
// - Look-ahead picks auto-precharge for next row miss
`timescale 1ns/10ps
`default_nettype none
module dpais_sched import dpais_pkg::*; #(
  parameter int LAT_DEPTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic cmd_last,
  input wire logic cmd_ap_req,
  output logic cmd_ready,
  input wire logic mem_clk,
  output logic [2:0] mem_cmd,
  output logic [RANK_W-1:0] mem_rank,
  output logic [BG_W-1:0] mem_bg,
  output logic [BA_W-1:0] mem_ba,
  output logic [CID_W-1:0] mem_cid,
  output logic [ROW_W-1:0] mem_addr,
  output logic mem_ap,
  output logic rd_expect,
  output logic wr_drive
);
  // --------
  // Register side (pclk)
  // --------
  logic [3:0] ctrl_reg, ctrl_next;
  logic [TIM_W-1:0] al_reg, al_next, cl_reg, cl_next;
  logic [TIM_W-1:0] rcd_reg, rcd_next, rp_reg, rp_next;
  logic clamp_reg, clamp_next;
  logic [CNT_W-1:0] acc_reg, acc_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic req_tgl_reg, req_tgl_next, ack_s1_reg, ack_s2_reg;
  logic cmd_ready_reg, cmd_ready_next;
  logic [WORD_W-1:0] word_reg, word_next;
  logic [RANK_W-1:0] m_rank;
  logic [BG_W-1:0] m_bg;
  logic [BA_W-1:0] m_ba;
  logic [CID_W-1:0] m_cid;
  logic [ROW_W-1:0] m_row;
  logic [COL_W-1:0] m_col;
  logic ack_tgl_reg, ack_tgl_next;

  dpais_addr_map u_map (
    .addr(cmd_addr),
    .order(ctrl_reg[CTRL_ORDER_LSB +: 2]),
    .x16(ctrl_reg[CTRL_X16_BIT]),
    .rank(m_rank),
    .bg(m_bg),
    .ba(m_ba),
    .cid(m_cid),
    .row(m_row),
    .col(m_col)
  );

  // APB slave, host command capture and crossing launch
  always_comb begin
    logic access, wr_fire, accept, hit;
    logic [TIM_W-1:0] al_w, rcd_w;
    access = psel && penable && !pready_reg;
    wr_fire = psel && penable && pready_reg && pwrite;
    accept = cmd_valid && cmd_ready_reg;
    hit = (paddr == CTRL_OFF) || (paddr == TIMING_OFF) ||
          (paddr == STATUS_OFF);
    al_w = pwdata[TIM_AL_LSB +: TIM_W];
    rcd_w = pwdata[TIM_RCD_LSB +: TIM_W];
    ctrl_next = ctrl_reg;
    al_next = al_reg;
    cl_next = cl_reg;
    rcd_next = rcd_reg;
    rp_next = rp_reg;
    clamp_next = clamp_reg;
    pready_next = access;
    pslverr_next = access && !hit;
    prdata_next = '0;
    if (access && !pwrite) begin
      case (paddr)
        CTRL_OFF: prdata_next[3:0] = ctrl_reg;
        TIMING_OFF: prdata_next[15:0] = {rp_reg, rcd_reg, cl_reg, al_reg};
        STATUS_OFF: begin
          prdata_next[STAT_BUSY_BIT] = req_tgl_reg != ack_s2_reg;
          prdata_next[STAT_CLAMP_BIT] = clamp_reg;
          prdata_next[STAT_CNT_LSB +: CNT_W] = acc_reg;
        end
        default: prdata_next = '0;
      endcase
    end
    if (wr_fire && paddr == CTRL_OFF) begin
      ctrl_next = pwdata[3:0];
    end
    if (wr_fire && paddr == TIMING_OFF) begin
      // Posted commands must never run ahead of the opened row
      al_next = (al_w > rcd_w) ? rcd_w : al_w;
      clamp_next = al_w > rcd_w;
      cl_next = pwdata[TIM_CL_LSB +: TIM_W];
      rcd_next = rcd_w;
      rp_next = pwdata[TIM_RP_LSB +: TIM_W];
    end
    req_tgl_next = req_tgl_reg;
    word_next = word_reg;
    acc_next = acc_reg;
    if (accept) begin
      req_tgl_next = !req_tgl_reg;
      acc_next = acc_reg + 1'b1;
      // Timing travels with each command so both domains agree
      word_next = {cmd_write, cmd_ap_req && cmd_last,
                   m_rank, m_bg, m_ba, m_cid, m_row, m_col,
                   al_reg, cl_reg, rcd_reg, rp_reg,
                   ctrl_reg[CTRL_LOOK_BIT]};
    end
    // One command in flight until the far side acks
    cmd_ready_next = !accept && (req_tgl_reg == ack_s2_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      al_reg <= AL_RST;
      cl_reg <= CL_RST;
      rcd_reg <= RCD_RST;
      rp_reg <= RP_RST;
      clamp_reg <= 1'b0;
      acc_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      req_tgl_reg <= 1'b0;
      word_reg <= '0;
      cmd_ready_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      al_reg <= al_next;
      cl_reg <= cl_next;
      rcd_reg <= rcd_next;
      rp_reg <= rp_next;
      clamp_reg <= clamp_next;
      acc_reg <= acc_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      req_tgl_reg <= req_tgl_next;
      word_reg <= word_next;
      cmd_ready_reg <= cmd_ready_next;
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign cmd_ready = cmd_ready_reg;

  // --------
  // Memory side (mem_clk)
  // --------
  typedef enum logic [2:0] {S_IDLE, S_DEC, S_RP, S_RCD} dpais_state_e;
  dpais_state_e st_reg, st_next;
  logic mrst_s1_reg, mrst_n;
  logic req_s1_reg, req_s2_reg;
  logic nx_vld_reg, nx_vld_next;
  logic [WORD_W-1:0] nx_reg, nx_next, cur_reg, cur_next;
  logic [NUM_BANKS-1:0] opn_reg, opn_next;
  logic [ROW_W-1:0] orow_reg [NUM_BANKS];
  logic [ROW_W-1:0] orow_next [NUM_BANKS];
  logic [TIM_W-1:0] cnt_reg, cnt_next;
  logic [BANK_IDX_W-1:0] apb_reg, apb_next;
  logic [LAT_W-1:0] apc_reg, apc_next;
  logic [2:0] mc_reg, mc_next;
  logic [BANK_IDX_W-1:0] mb_reg, mb_next;
  logic [CID_W-1:0] mcid_reg, mcid_next;
  logic [ROW_W-1:0] ma_reg, ma_next;
  logic map_reg, map_next, rd_stb, wr_stb;
  logic c_wr, c_ap, c_look, n_wr, n_ap, n_look;
  logic [BANK_IDX_W-1:0] c_bank, n_bank;
  logic [CID_W-1:0] c_cid, n_cid;
  logic [ROW_W-1:0] c_row, n_row;
  logic [COL_W-1:0] c_col, n_col;
  logic [TIM_W-1:0] c_al, c_cl, c_rcd, c_rp;
  logic [TIM_W-1:0] n_al, n_cl, n_rcd, n_rp;
  logic [LAT_W-1:0] rd_lat, wr_lat;

  // Page identity is rank, bank group and bank plus the row
  assign {c_wr, c_ap, c_bank, c_cid, c_row, c_col,
          c_al, c_cl, c_rcd, c_rp, c_look} = cur_reg;
  assign {n_wr, n_ap, n_bank, n_cid, n_row, n_col,
          n_al, n_cl, n_rcd, n_rp, n_look} = nx_reg;
  assign rd_lat = {1'b0, c_al} + {1'b0, c_cl};
  assign wr_lat = (rd_lat == '0) ? rd_lat : rd_lat - 1'b1;

  // Reset release is synchronised to the link clock
  always_ff @(posedge mem_clk or negedge presetn) begin
    if (!presetn) begin
      mrst_s1_reg <= 1'b0;
      mrst_n <= 1'b0;
    end else begin
      mrst_s1_reg <= 1'b1;
      mrst_n <= mrst_s1_reg;
    end
  end

  // Bank scheduler
  always_comb begin
    logic do_act, do_cas, la_ap;
    logic [TIM_W-1:0] gap, rp1;
    st_next = st_reg;
    nx_vld_next = nx_vld_reg;
    nx_next = nx_reg;
    cur_next = cur_reg;
    opn_next = opn_reg;
    orow_next = orow_reg;
    cnt_next = (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1;
    apb_next = apb_reg;
    apc_next = (apc_reg == '0) ? apc_reg : apc_reg - 1'b1;
    ack_tgl_next = ack_tgl_reg;
    mc_next = MC_NOP;
    mb_next = c_bank;
    mcid_next = c_cid;
    ma_next = '0;
    map_next = 1'b0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    do_act = 1'b0;
    do_cas = 1'b0;
    // Posted command waits only tRCD minus AL, at least one cycle
    gap = (c_rcd > c_al) ? c_rcd - c_al : 4'h1;
    rp1 = (c_rp == '0) ? 4'h1 : c_rp;
    la_ap = c_look && nx_vld_reg && n_bank == c_bank && n_row != c_row;
    case (st_reg)
      S_IDLE: begin
        if (nx_vld_reg) begin
          cur_next = nx_reg;
          nx_vld_next = 1'b0;
          st_next = S_DEC;
        end
      end
      S_DEC: begin
        if (apc_reg != '0 && apb_reg == c_bank) begin
          st_next = S_DEC; // Bank still closing from auto-precharge
        end else if (opn_reg[c_bank] && orow_reg[c_bank] == c_row) begin
          do_cas = 1'b1;
        end else if (opn_reg[c_bank]) begin
          mc_next = MC_PRE;
          opn_next[c_bank] = 1'b0;
          cnt_next = rp1 - 1'b1;
          st_next = S_RP;
        end else begin
          do_act = 1'b1;
        end
      end
      S_RP: begin
        if (cnt_reg == '0) begin
          do_act = 1'b1;
        end
      end
      S_RCD: begin
        if (cnt_reg == '0) begin
          do_cas = 1'b1;
        end
      end
      default: st_next = S_IDLE;
    endcase
    if (do_act) begin
      mc_next = MC_ACT;
      ma_next = c_row;
      opn_next[c_bank] = 1'b1;
      orow_next[c_bank] = c_row;
      cnt_next = gap - 1'b1;
      st_next = S_RCD;
    end
    if (do_cas) begin
      mc_next = c_wr ? MC_WR : MC_RD;
      ma_next = {{(ROW_W - COL_W){1'b0}}, c_col};
      map_next = c_ap || la_ap;
      rd_stb = !c_wr;
      wr_stb = c_wr;
      if (c_ap || la_ap) begin
        opn_next[c_bank] = 1'b0;
        apb_next = c_bank;
        apc_next = {1'b0, c_al} + {1'b0, rp1};
      end
      // Next command decodes at once so banks overlap
      st_next = nx_vld_reg ? S_DEC : S_IDLE;
      if (nx_vld_reg) begin
        cur_next = nx_reg;
        nx_vld_next = 1'b0;
      end
    end
    // Mailbox fills when empty; ack frees host
    if (!nx_vld_reg && req_s2_reg != ack_tgl_reg) begin
      nx_next = word_reg;
      nx_vld_next = 1'b1;
      ack_tgl_next = req_s2_reg;
    end
  end

  always_ff @(posedge mem_clk or negedge mrst_n) begin
    if (!mrst_n) begin
      st_reg <= S_IDLE;
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      nx_vld_reg <= 1'b0;
      nx_reg <= '0;
      cur_reg <= '0;
      opn_reg <= '0;
      for (int i = 0; i < NUM_BANKS; i++) begin
        orow_reg[i] <= '0;
      end
      cnt_reg <= '0;
      apb_reg <= '0;
      apc_reg <= '0;
      mc_reg <= MC_NOP;
      mb_reg <= '0;
      mcid_reg <= '0;
      ma_reg <= '0;
      map_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      ack_tgl_reg <= ack_tgl_next;
      nx_vld_reg <= nx_vld_next;
      nx_reg <= nx_next;
      cur_reg <= cur_next;
      opn_reg <= opn_next;
      orow_reg <= orow_next;
      cnt_reg <= cnt_next;
      apb_reg <= apb_next;
      apc_reg <= apc_next;
      mc_reg <= mc_next;
      mb_reg <= mb_next;
      mcid_reg <= mcid_next;
      ma_reg <= ma_next;
      map_reg <= map_next;
    end
  end

  // Data strobes trail the column command
  dpais_lat_pipe #(.DEPTH(LAT_DEPTH), .LW(LAT_W)) u_rd_lat (
    .clk(mem_clk),
    .rst_n(mrst_n),
    .strobe(rd_stb),
    .lat(rd_lat),
    .pulse(rd_expect)
  );

  dpais_lat_pipe #(.DEPTH(LAT_DEPTH), .LW(LAT_W)) u_wr_lat (
    .clk(mem_clk),
    .rst_n(mrst_n),
    .strobe(wr_stb),
    .lat(wr_lat),
    .pulse(wr_drive)
  );

  assign mem_cmd = mc_reg;
  assign {mem_rank, mem_bg, mem_ba} = mb_reg;
  assign mem_cid = mcid_reg;
  assign mem_addr = ma_reg;
  assign mem_ap = map_reg;
endmodule : dpais_sched
`default_nettype wire

// file: hdl/dpais_pkg.sv
package dpais_pkg;
  // --------
  // Address field widths
  // --------
  localparam int RANK_W = 1;
  localparam int BG_W = 2;
  localparam int BA_W = 2;
  localparam int CID_W = 1;
  localparam int ROW_W = 15;
  localparam int COL_W = 10;
  localparam int ADDR_W = RANK_W + BG_W + BA_W + CID_W + ROW_W + COL_W;
  localparam int BANK_IDX_W = RANK_W + BG_W + BA_W;
  localparam int NUM_BANKS = 1 << BANK_IDX_W;
  localparam int TIM_W = 4;
  localparam int LAT_W = 5;
  localparam int CNT_W = 16;
  localparam int WORD_W = 2 + ADDR_W + 4 * TIM_W + 1;
  // Sixteen-bit devices use only the low bank group bit
  localparam logic [BG_W-1:0] BG_MASK_X16 = 2'h1;
  // --------
  // Register map (byte addresses) and field positions
  // --------
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] CTRL_OFF = 12'h000;
  localparam logic [APB_AW-1:0] TIMING_OFF = 12'h004;
  localparam logic [APB_AW-1:0] STATUS_OFF = 12'h008;
  localparam int CTRL_ORDER_LSB = 0;
  localparam int CTRL_X16_BIT = 2;
  localparam int CTRL_LOOK_BIT = 3;
  localparam int TIM_AL_LSB = 0;
  localparam int TIM_CL_LSB = 4;
  localparam int TIM_RCD_LSB = 8;
  localparam int TIM_RP_LSB = 12;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CLAMP_BIT = 1;
  localparam int STAT_CNT_LSB = 16;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [TIM_W-1:0] AL_RST = 4'h0;
  localparam logic [TIM_W-1:0] CL_RST = 4'h5;
  localparam logic [TIM_W-1:0] RCD_RST = 4'h5;
  localparam logic [TIM_W-1:0] RP_RST = 4'h5;
  // --------
  // Address orderings and memory command codes
  // --------
  localparam logic [1:0] ORD_RANK_FIRST = 2'h0;
  localparam logic [1:0] ORD_BANK_IL = 2'h1;
  localparam logic [1:0] ORD_BANK_IL_VAR = 2'h2;
  localparam logic [1:0] ORD_RANK_BANK_IL = 2'h3;
  localparam logic [2:0] MC_NOP = 3'h0;
  localparam logic [2:0] MC_ACT = 3'h1;
  localparam logic [2:0] MC_PRE = 3'h2;
  localparam logic [2:0] MC_RD = 3'h3;
  localparam logic [2:0] MC_WR = 3'h4;
endpackage : dpais_pkg

// file: hdl/dpais_addr_map.sv
`timescale 1ns/10ps
`default_nettype none
module dpais_addr_map import dpais_pkg::*; (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [1:0] order,
  input wire logic x16,
  output logic [RANK_W-1:0] rank,
  output logic [BG_W-1:0] bg,
  output logic [BA_W-1:0] ba,
  output logic [CID_W-1:0] cid,
  output logic [ROW_W-1:0] row,
  output logic [COL_W-1:0] col
);
  // --------
  // Field positions per ordering, counted from the least significant bit
  // --------
  always_comb begin
    int bgw, p_rk, p_bg, p_ba, p_cid, p_row, p_col;
    logic [ADDR_W-1:0] t_rk, t_bg, t_ba, t_cid, t_row, t_col;
    bgw = x16 ? 1 : BG_W;
    p_bg = 0;
    p_col = bgw;
    p_ba = bgw + COL_W;
    p_rk = p_ba + BA_W;
    p_row = p_rk + RANK_W;
    p_cid = p_row + ROW_W;
    case (order)
      ORD_RANK_FIRST: begin
        p_col = 0;
        p_row = COL_W;
        p_cid = COL_W + ROW_W;
        p_ba = p_cid + CID_W;
        p_bg = p_ba + BA_W;
        p_rk = p_bg + bgw;
      end
      ORD_BANK_IL: begin
        p_bg = 0;
        p_ba = bgw;
        p_col = bgw + BA_W;
        p_row = p_col + COL_W;
        p_cid = p_row + ROW_W;
        p_rk = p_cid + CID_W;
      end
      ORD_BANK_IL_VAR: begin
        p_bg = 0;
        p_col = bgw;
        p_ba = bgw + COL_W;
        p_row = p_ba + BA_W;
        p_cid = p_row + ROW_W;
        p_rk = p_cid + CID_W;
      end
      default: begin
      end
    endcase
    t_rk = addr >> p_rk;
    t_bg = addr >> p_bg;
    t_ba = addr >> p_ba;
    t_cid = addr >> p_cid;
    t_row = addr >> p_row;
    t_col = addr >> p_col;
    rank = t_rk[RANK_W-1:0];
    bg = x16 ? (t_bg[BG_W-1:0] & BG_MASK_X16) : t_bg[BG_W-1:0];
    ba = t_ba[BA_W-1:0];
    cid = t_cid[CID_W-1:0];
    row = t_row[ROW_W-1:0];
    col = t_col[COL_W-1:0];
  end
endmodule : dpais_addr_map
`default_nettype wire

// file: hdl/dpais_lat_pipe.sv
`timescale 1ns/10ps
`default_nettype none
module dpais_lat_pipe #(
  parameter int DEPTH = 32,
  parameter int LW = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe,
  input wire logic [LW-1:0] lat,
  output logic pulse
);
  logic [DEPTH-1:0] sr_reg, sr_next;
  logic pulse_reg, pulse_next;

  // Delay line; the tap picks the programmed latency
  always_comb begin
    sr_next = {sr_reg[DEPTH-2:0], strobe};
    pulse_next = (lat == '0) ? strobe : sr_reg[lat - 1'b1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      sr_reg <= sr_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;
endmodule : dpais_lat_pipe
`default_nettype wire

// file: verif/dpais_sched_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dpais_sched_chk import dpais_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic mem_clk,
  input wire logic [2:0] mem_cmd,
  input wire logic [RANK_W-1:0] mem_rank,
  input wire logic [BG_W-1:0] mem_bg,
  input wire logic [BA_W-1:0] mem_ba,
  input wire logic [ROW_W-1:0] mem_addr,
  input wire logic mem_ap,
  input wire logic rd_expect,
  input wire logic wr_drive
);
  // --------
  // Helper state and properties
  // --------
  logic [5:0] since_rd;
  logic [5:0] since_wr;
  logic [BANK_IDX_W-1:0] act_bank;
  logic col_cmd;
  assign col_cmd = (mem_cmd == MC_RD) || (mem_cmd == MC_WR);
  // Ages saturate so idle never wraps
  always_ff @(posedge mem_clk or negedge presetn) begin
    if (!presetn) begin
      since_rd <= 6'h3f;
      since_wr <= 6'h3f;
      act_bank <= '0;
    end else begin
      since_rd <= (mem_cmd == MC_RD) ? 6'h1
        : since_rd + {5'h0, since_rd != 6'h3f};
      since_wr <= (mem_cmd == MC_WR) ? 6'h1
        : since_wr + {5'h0, since_wr != 6'h3f};
      if (mem_cmd == MC_ACT) act_bank <= {mem_rank, mem_bg, mem_ba};
    end
  end
  a_ap_col_only: assert property (@(posedge mem_clk) disable iff (!presetn)
    mem_ap |-> col_cmd) else $error("ap outside column command");
  a_col_zero_ext: assert property (@(posedge mem_clk) disable iff (!presetn)
    col_cmd |-> mem_addr[ROW_W-1:COL_W] == '0)
    else $error("column not zero extended");
  a_act_then_col: assert property (@(posedge mem_clk) disable iff (!presetn)
    mem_cmd == MC_ACT |-> ##[1:16] (col_cmd
    && {mem_rank, mem_bg, mem_ba} == act_bank))
    else $error("no column command after activate");
  a_pre_no_col: assert property (@(posedge mem_clk) disable iff (!presetn)
    mem_cmd == MC_PRE |=> !col_cmd ##[0:14] mem_cmd == MC_ACT)
    else $error("column command right after precharge");
  a_rd_lat_cause: assert property (@(posedge mem_clk) disable iff (!presetn)
    rd_expect |-> since_rd <= 6'h1e)
    else $error("read data slot without read");
  a_wr_lat_cause: assert property (@(posedge mem_clk) disable iff (!presetn)
    wr_drive |-> since_wr <= 6'h1d)
    else $error("write data slot without write");
  a_take_drops_ready: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready held after take");
  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> !pready ##1 pready)
    else $error("apb answer late or early");
  a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && $past(psel))
    else $error("error outside access");
  c_act_rd: cover property (@(posedge mem_clk) mem_cmd == MC_ACT ##1
    mem_cmd == MC_RD);
  c_ap_rd: cover property (@(posedge mem_clk) mem_ap && col_cmd);
  c_pre: cover property (@(posedge mem_clk) mem_cmd == MC_PRE);
endmodule : dpais_sched_chk
bind dpais_sched dpais_sched_chk chk_u (.*);
`default_nettype wire

// file: verif/dpais_ddr4_model.sv
`timescale 1ns/10ps
`default_nettype none
module dpais_ddr4_model import dpais_pkg::*; (
  input wire logic mem_clk,
  input wire logic presetn,
  input wire logic [2:0] mem_cmd,
  input wire logic [RANK_W-1:0] mem_rank,
  input wire logic [BG_W-1:0] mem_bg,
  input wire logic [BA_W-1:0] mem_ba,
  input wire logic [CID_W-1:0] mem_cid,
  input wire logic [ROW_W-1:0] mem_addr,
  input wire logic mem_ap,
  input wire logic rd_expect,
  input wire logic wr_drive,
  input wire logic [TIM_W-1:0] al,
  input wire logic [TIM_W-1:0] rcd,
  output logic [15:0] fault_cnt
);
  // --------
  // Bank state and command log
  // --------
  typedef struct packed {
    logic [2:0] cmd;
    logic [BANK_IDX_W+CID_W-1:0] bank;
    logic [ROW_W-1:0] addr;
    logic ap;
    int cyc;
  } dpais_ev_s;
  dpais_ev_s log[$];
  int rde_q[$];
  int wrd_q[$];
  int now;
  logic open_b [NUM_BANKS];
  int act_b [NUM_BANKS];
  logic [BANK_IDX_W-1:0] bk;
  assign bk = {mem_rank, mem_bg, mem_ba};
  // Logs commands; posted ones run al cycles later
  always @(posedge mem_clk or negedge presetn) begin
    if (!presetn) begin
      now = 0;
      fault_cnt = '0;
      foreach (open_b[i]) open_b[i] = 1'b0;
    end else begin
      now = now + 1;
      if (mem_cmd != MC_NOP)
        log.push_back('{mem_cmd, {bk, mem_cid}, mem_addr, mem_ap, now});
      if (rd_expect) rde_q.push_back(now);
      if (wr_drive) wrd_q.push_back(now);
      if (mem_cmd == MC_ACT) begin
        if (open_b[bk]) fault_cnt = fault_cnt + 16'h1;
        open_b[bk] = 1'b1;
        act_b[bk] = now;
      end
      if (mem_cmd == MC_PRE) open_b[bk] = 1'b0;
      if (mem_cmd == MC_RD || mem_cmd == MC_WR) begin
        // Row must be ready when the held command executes
        if (!open_b[bk] || now + al < act_b[bk] + rcd)
          fault_cnt = fault_cnt + 16'h1;
        if (mem_ap) open_b[bk] = 1'b0;
      end
    end
  end
endmodule : dpais_ddr4_model
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import dpais_pkg::*;;
  logic pclk, mem_clk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic cmd_valid, cmd_write, cmd_last, cmd_ap_req, cmd_ready, mem_ap, e;
  logic [ADDR_W-1:0] cmd_addr;
  logic [2:0] mem_cmd;
  logic [RANK_W-1:0] mem_rank;
  logic [BG_W-1:0] mem_bg;
  logic [BA_W-1:0] mem_ba;
  logic [CID_W-1:0] mem_cid;
  logic [ROW_W-1:0] mem_addr;
  logic rd_expect, wr_drive;
  logic [TIM_W-1:0] al, rcd;
  logic [15:0] fault_cnt;
  int n_mismatch, n_tests, n_cyc;
  dpais_sched dut_u (.*);
  dpais_ddr4_model mem_u (.*);
  // --------
  // Clocks, timeout and shared tasks
  // --------
  always #2 pclk = ~pclk;
  // Offset so edges never meet pclk edges
  initial begin
    #7;
    forever #24 mem_clk = ~mem_clk;
  end
  always @(posedge pclk) begin
    n_cyc++;
    if (n_cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d = '0);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Host holds the beat until taken
  task automatic host(input logic w, input logic [ADDR_W-1:0] a,
                      input logic l, input logic ap);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_last <= l;
    cmd_ap_req <= ap;
    do @(posedge pclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask : host
  task automatic wait_ev(input int n, input int nr, input int nw);
    int k;
    k = 0;
    while ((mem_u.log.size() < n || mem_u.rde_q.size() < nr
            || mem_u.wrd_q.size() < nw) && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    check(mem_u.log.size() == n, "command count");
  endtask : wait_ev
  task automatic clr(input logic [31:0] ctrl);
    apb(1'b1, CTRL_OFF, ctrl);
    mem_u.log.delete();
    mem_u.rde_q.delete();
    mem_u.wrd_q.delete();
  endtask : clr
  task automatic ev(input int i, input logic [2:0] c, input logic [5:0] b,
                    input logic [ROW_W-1:0] a, input logic ap);
    check(mem_u.log[i].cmd === c && mem_u.log[i].bank === b
      && mem_u.log[i].addr === a && mem_u.log[i].ap === ap, "command");
  endtask : ev
  // b packs rank, bank group, bank, chip ID
  function automatic logic [ADDR_W-1:0] mk(input logic [1:0] o,
      input logic [5:0] b, input logic [ROW_W-1:0] w,
      input logic [COL_W-1:0] c);
    case (o)
      ORD_RANK_FIRST: return {b, w, c};
      ORD_BANK_IL: return {b[5], b[0], w, c, b[2:1], b[4:3]};
      ORD_BANK_IL_VAR: return {b[5], b[0], w, b[2:1], c, b[4:3]};
      default: return {b[0], w, b[5], b[2:1], c, b[4:3]};
    endcase
  endfunction : mk
  // --------
  // Scenarios
  // --------
  task automatic t_regs();
    apb(1'b0, TIMING_OFF);
    check(r === 32'h5550 && e === 1'b0, "timing reset");
    apb(1'b0, 12'h00c);
    check(r === 32'h0 && e === 1'b1, "unmapped");
    apb(1'b1, TIMING_OFF, 32'h3557);
    apb(1'b0, TIMING_OFF);
    check(r === 32'h3555, "al clamp");
    apb(1'b0, STATUS_OFF);
    check(r[STAT_CLAMP_BIT] === 1'b1, "clamp flag");
    apb(1'b1, TIMING_OFF, 32'h3554);
    apb(1'b1, STATUS_OFF, 32'hffffffff);
    apb(1'b0, STATUS_OFF);
    check(r[STAT_CLAMP_BIT] === 1'b0 && e === 1'b0, "status ro");
    al = 4'h4;
  endtask : t_regs
  task automatic t_orders();
    logic [1:0] o;
    logic [5:0] b;
    for (int i = 0; i < 4; i++) begin
      o = 2'(i);
      b = {o[0], o, ~o, ~o[0]};
      clr({30'h0, o});
      host(1'b0, mk(o, b, 15'h1a5 + 15'(i), 10'h2c + 10'(i)), 1'b1, 1'b1);
      wait_ev(2, 1, 0);
      ev(0, MC_ACT, b, 15'h1a5 + 15'(i), 1'b0);
      ev(1, MC_RD, b, 15'h2c + 15'(i), 1'b1);
      check(mem_u.log[1].cyc - mem_u.log[0].cyc == 1, "act gap");
      check(mem_u.rde_q[0] - mem_u.log[1].cyc == 9, "rd lat");
    end
  endtask : t_orders
  task automatic t_page();
    clr(32'h0);
    host(1'b1, mk(2'h0, 6'h26, 15'h11, 10'h5), 1'b1, 1'b0);
    host(1'b1, mk(2'h0, 6'h26, 15'h11, 10'h6), 1'b1, 1'b0);
    host(1'b0, mk(2'h0, 6'h26, 15'h22, 10'h5), 1'b1, 1'b1);
    wait_ev(6, 1, 2);
    check(mem_u.wrd_q[0] - mem_u.log[1].cyc == 8, "wr lat");
    ev(2, MC_WR, 6'h26, 15'h6, 1'b0);
    ev(3, MC_PRE, 6'h26, 15'h0, 1'b0);
    ev(4, MC_ACT, 6'h26, 15'h22, 1'b0);
    check(mem_u.log[4].cyc - mem_u.log[3].cyc == 3, "pre gap");
  endtask : t_page
  task automatic t_ap_last();
    clr(32'h1);
    host(1'b0, mk(2'h1, 6'h31, 15'h7, 10'h1), 1'b0, 1'b1);
    host(1'b0, mk(2'h1, 6'h31, 15'h8, 10'h1), 1'b1, 1'b1);
    host(1'b0, mk(2'h1, 6'h31, 15'h7, 10'h1), 1'b1, 1'b0);
    wait_ev(7, 3, 0);
    ev(1, MC_RD, 6'h31, 15'h1, 1'b0);
    ev(2, MC_PRE, 6'h31, 15'h0, 1'b0);
    ev(4, MC_RD, 6'h31, 15'h1, 1'b1);
    ev(5, MC_ACT, 6'h31, 15'h7, 1'b0);
  endtask : t_ap_last
  task automatic t_groups();
    clr(32'h5);
    host(1'b0, 31'h7fffffff, 1'b1, 1'b1);
    wait_ev(2, 1, 0);
    check(mem_u.log[0].bank[4] === 1'b0, "x16 bank group");
    clr(32'h1);
    for (int i = 0; i < 4; i++) host(1'b0, 31'(i), 1'b1, 1'b1);
    wait_ev(8, 4, 0);
    for (int i = 0; i < 4; i++) begin
      ev(2 * i, MC_ACT, {1'b0, 2'(i), 3'h0}, 15'h0, 1'b0);
      ev(2 * i + 1, MC_RD, {1'b0, 2'(i), 3'h0}, 15'h0, 1'b1);
    end
  endtask : t_groups
  task automatic t_look();
    apb(1'b1, TIMING_OFF, 32'h3f50);
    clr(32'h9);
    {al, rcd} = 8'h0f;
    host(1'b0, 31'h10, 1'b1, 1'b0);
    host(1'b0, 31'h4010, 1'b1, 1'b0);
    wait_ev(4, 2, 0);
    ev(1, MC_RD, 6'h0, 15'h1, 1'b1);
    ev(2, MC_ACT, 6'h0, 15'h1, 1'b0);
  endtask : t_look
  // Reset, then each scenario in turn
  initial begin
    {pclk, mem_clk, presetn, psel, penable, pwrite, cmd_valid} = '0;
    {cmd_write, cmd_last, cmd_ap_req, paddr, pwdata, cmd_addr} = '0;
    {n_mismatch, n_tests, n_cyc} = '0;
    al = AL_RST;
    rcd = RCD_RST;
    repeat (16) @(posedge pclk);
    check(cmd_ready === 1'b0 && mem_cmd === MC_NOP, "reset outputs");
    presetn <= 1'b1;
    t_regs();
    t_orders();
    t_page();
    t_ap_last();
    t_groups();
    t_look();
    check(fault_cnt === 16'h0, "memory protocol");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
